// ===== hw/oswc_pkg.sv
// Purpose: Constants for the oscillator select and warm-up control block
// Assumes: AHB-Lite word registers, 25 MHz bus clock
// Notes:   Offsets are byte addresses
package oswc_pkg;
  localparam logic [4:0]  OSWC_OFF_CTRL      = 5'h04;
  localparam logic [4:0]  OSWC_OFF_IRQ_STAT  = 5'h10;
  localparam logic [4:0]  OSWC_OFF_IRQ_EN    = 5'h14;
  localparam logic [4:0]  OSWC_OFF_IRQ_CLR   = 5'h18;
  localparam int          OSWC_WU_TIME_LSB   = 20;
  localparam int          OSWC_WU_TIME_MSB   = 31;
  localparam int          OSWC_WU_SRC_BIT    = 19;
  localparam int          OSWC_XTAL_BIT      = 18;
  localparam int          OSWC_HS_SRC_BIT    = 17;
  localparam int          OSWC_INT_EN_BIT    = 16;
  localparam int          OSWC_WAZ_HI_LSB    = 12;
  localparam int          OSWC_WAZ_HI_MSB    = 15;
  localparam int          OSWC_WAZ_MID_BIT   = 9;
  localparam int          OSWC_EXT_EN_BIT    = 8;
  localparam int          OSWC_ALT_WU_BIT    = 3;
  localparam int          OSWC_PLL_EN_BIT    = 2;
  localparam int          OSWC_WU_BUSY_BIT   = 1;
  localparam int          OSWC_WU_START_BIT  = 0;
  localparam logic [11:0] OSWC_WU_TIME_RST   = 12'h800;
  localparam logic        OSWC_INT_EN_RST    = 1'h1;
  localparam int          OSWC_EV_WU_DONE    = 0;
  localparam int          OSWC_EV_XTAL_REF   = 1;
  localparam int          OSWC_EV_HS_EXT     = 2;
  localparam int          OSWC_NUM_EV        = 3;
endpackage : oswc_pkg

// ===== hw/oswc_top.sv
// Purpose: Oscillation control register, warm-up timer and interrupt logic
// Assumes: Single AHB-Lite master, oscillator clocks slower than CLK/2
// Notes:   Reads take one wait state, writes none
// Contract
// R01: Twelve-bit read/write warm-up count in 31:20
// R02: Bit 19 picks warm-up timer clock
// R03: Bit 18 hands shared pins to crystal
// R04: Software keeps shared port registers disabled
// R05: Bit 17 selects high-speed clock source
// R06: Software polls source select, then stops internal
// R07: Software never reselects internal after switching
// R08: Bit 16 runs internal oscillator, reset one
// R09: Bit 8 runs external oscillator, reset zero
// R10: Bit 2 runs PLL, reset zero
// R11: Software writes zero to reserved bits
// R12: Bit 1 reads one while warming up
// R13: Writing one to bit 0 starts warm-up
// R14: No manual start with automatic stop warm-up
// R15: Pin assignment blocks port, refused unless reset
// R16: Timer counts source edges to count time
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
module oswc_top
  import oswc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        INT_OSC_CLK,
  input  wire logic        EXT_OSC_CLK,
  input  wire logic        PORT_REGS_AT_RESET,
  output logic             INT_OSC_EN,
  output logic             EXT_OSC_EN,
  output logic             PLL_EN,
  output logic             HS_SRC_EXT,
  output logic             WARMUP_SRC_EXT,
  output logic             XTAL_PIN_ASSIGN,
  output logic             WARMUP_BUSY,
  output logic             IRQ
);

  typedef struct packed {
    logic [11:0]            wu_time;
    logic                   wu_src;
    logic                   xtal;
    logic                   hs_src;
    logic                   int_en;
    logic [3:0]             waz_hi;
    logic                   waz_mid;
    logic                   ext_en;
    logic                   alt_wu;
    logic                   pll_en;
    logic                   wu_busy;
    logic [11:0]            wu_cnt;
    logic [1:0]             int_sync;
    logic [1:0]             ext_sync;
    logic                   src_prev;
    logic [OSWC_NUM_EV-1:0] ev_stat;
    logic [OSWC_NUM_EV-1:0] ev_en;
    logic                   dph_wr;
    logic                   rd_pend;
    logic [4:0]             addr;
    logic [31:0]            rdata;
  } oswc_state_t;

  oswc_state_t st_r;
  oswc_state_t st_nxt;

  function automatic logic hits(input logic [4:0] a, input logic [4:0] off);
    hits = (a == off);
  endfunction : hits

  logic        addr_ok;
  logic        src_lvl;
  logic        src_edge;
  logic        ctrl_wr;
  logic        start;
  logic        xtal_req;
  logic [31:0] ctrl_rd;
  logic [OSWC_NUM_EV-1:0] ev_set;

  assign addr_ok = HSEL && HTRANS[1] && HREADY;
  assign ctrl_wr = st_r.dph_wr && hits(st_r.addr, OSWC_OFF_CTRL);
  assign start   = ctrl_wr && HWDATA[OSWC_WU_START_BIT]; // R13
  assign xtal_req = ctrl_wr && HWDATA[OSWC_XTAL_BIT] && !st_r.xtal;
  // Edge taken after the second stage only
  assign src_lvl  = st_r.wu_src ? st_r.ext_sync[1] : st_r.int_sync[1]; // R02
  assign src_edge = src_lvl && !st_r.src_prev;

  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[OSWC_WU_TIME_MSB:OSWC_WU_TIME_LSB] = st_r.wu_time; // R01
    ctrl_rd[OSWC_WU_SRC_BIT]                   = st_r.wu_src;
    ctrl_rd[OSWC_XTAL_BIT]                     = st_r.xtal;
    ctrl_rd[OSWC_HS_SRC_BIT]                   = st_r.hs_src;
    ctrl_rd[OSWC_INT_EN_BIT]                   = st_r.int_en;
    ctrl_rd[OSWC_WAZ_HI_MSB:OSWC_WAZ_HI_LSB]   = st_r.waz_hi;
    ctrl_rd[OSWC_WAZ_MID_BIT]                  = st_r.waz_mid;
    ctrl_rd[OSWC_EXT_EN_BIT]                   = st_r.ext_en;
    ctrl_rd[OSWC_ALT_WU_BIT]                   = st_r.alt_wu;
    ctrl_rd[OSWC_PLL_EN_BIT]                   = st_r.pll_en;
    ctrl_rd[OSWC_WU_BUSY_BIT]                  = st_r.wu_busy; // R12
  end

  always_comb begin
    st_nxt = st_r;
    ev_set = '0;
    st_nxt.int_sync = {st_r.int_sync[0], INT_OSC_CLK};
    st_nxt.ext_sync = {st_r.ext_sync[0], EXT_OSC_CLK};
    st_nxt.src_prev = src_lvl;

    // Bus address phase; reads stall one cycle so data comes from a flop
    st_nxt.dph_wr = 1'b0;
    if (st_r.rd_pend) begin
      st_nxt.rd_pend = 1'b0;
      if (hits(st_r.addr, OSWC_OFF_CTRL))
        st_nxt.rdata = ctrl_rd;
      else if (hits(st_r.addr, OSWC_OFF_IRQ_STAT))
        st_nxt.rdata = {29'h0000_0000, st_r.ev_stat};
      else if (hits(st_r.addr, OSWC_OFF_IRQ_EN))
        st_nxt.rdata = {29'h0000_0000, st_r.ev_en};
      else
        st_nxt.rdata = 32'h0000_0000;
    end else if (addr_ok) begin
      st_nxt.addr    = (HADDR[31:5] == 27'h000_0000) ? HADDR[4:0] : 5'h1F;
      st_nxt.dph_wr  = HWRITE;
      st_nxt.rd_pend = !HWRITE;
    end

    if (ctrl_wr) begin
      st_nxt.wu_time = HWDATA[OSWC_WU_TIME_MSB:OSWC_WU_TIME_LSB]; // R01
      st_nxt.wu_src  = HWDATA[OSWC_WU_SRC_BIT]; // R02
      st_nxt.hs_src  = HWDATA[OSWC_HS_SRC_BIT]; // R05
      st_nxt.int_en  = HWDATA[OSWC_INT_EN_BIT]; // R08
      st_nxt.waz_hi  = HWDATA[OSWC_WAZ_HI_MSB:OSWC_WAZ_HI_LSB];
      st_nxt.waz_mid = HWDATA[OSWC_WAZ_MID_BIT];
      st_nxt.ext_en  = HWDATA[OSWC_EXT_EN_BIT]; // R09
      st_nxt.alt_wu  = HWDATA[OSWC_ALT_WU_BIT];
      st_nxt.pll_en  = HWDATA[OSWC_PLL_EN_BIT]; // R10
      // Setting is refused while the port is not at its reset state
      if (!HWDATA[OSWC_XTAL_BIT])
        st_nxt.xtal = 1'b0; // R03
      else if (PORT_REGS_AT_RESET)
        st_nxt.xtal = 1'b1; // R15
      if (xtal_req && !PORT_REGS_AT_RESET)
        ev_set[OSWC_EV_XTAL_REF] = 1'b1; // R15
      if (HWDATA[OSWC_HS_SRC_BIT] && !st_r.hs_src)
        ev_set[OSWC_EV_HS_EXT] = 1'b1;
    end

    // Warm-up timer; a restart while busy reloads from zero
    if (start) begin
      st_nxt.wu_busy = 1'b1; // R13
      st_nxt.wu_cnt  = 12'h000;
    end else if (st_r.wu_busy) begin
      if (st_r.wu_cnt == st_r.wu_time) begin
        st_nxt.wu_busy = 1'b0; // R16
        ev_set[OSWC_EV_WU_DONE] = 1'b1;
      end else if (src_edge) begin
        st_nxt.wu_cnt = st_r.wu_cnt + 12'h001; // R16
      end
    end

    if (st_r.dph_wr && hits(st_r.addr, OSWC_OFF_IRQ_EN))
      st_nxt.ev_en = HWDATA[OSWC_NUM_EV-1:0];
    // Set beats clear in the same cycle
    if (st_r.dph_wr && hits(st_r.addr, OSWC_OFF_IRQ_CLR))
      st_nxt.ev_stat = st_r.ev_stat & ~HWDATA[OSWC_NUM_EV-1:0];
    st_nxt.ev_stat = st_nxt.ev_stat | ev_set;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r         <= '0;
      st_r.wu_time <= OSWC_WU_TIME_RST;
      st_r.int_en  <= OSWC_INT_EN_RST; // R08
    end else begin
      st_r <= st_nxt;
    end
  end

  assign HRDATA          = st_r.rdata;
  assign HREADYOUT       = !st_r.rd_pend;
  assign HRESP           = 1'b0;
  assign INT_OSC_EN      = st_r.int_en; // R08
  assign EXT_OSC_EN      = st_r.ext_en; // R09
  assign PLL_EN          = st_r.pll_en; // R10
  assign HS_SRC_EXT      = st_r.hs_src; // R05
  assign WARMUP_SRC_EXT  = st_r.wu_src; // R02
  assign XTAL_PIN_ASSIGN = st_r.xtal; // R03
  assign WARMUP_BUSY     = st_r.wu_busy; // R12
  assign IRQ             = |(st_r.ev_stat & st_r.ev_en);

  // Control fields: a write lands one edge after the data phase
  count_field_a: assert property (@(posedge CLK) disable iff (!RST_B) // R01
    ctrl_wr |=> (ctrl_rd[31:20] == $past(HWDATA[31:20])))
    else $error("warm-up count not stored");
  wu_src_out_a: assert property (@(posedge CLK) disable iff (!RST_B) // R02
    ctrl_wr |=> (WARMUP_SRC_EXT == $past(HWDATA[OSWC_WU_SRC_BIT])))
    else $error("warm-up source select wrong");
  xtal_refuse_a: assert property (@(posedge CLK) disable iff (!RST_B) // R15
    (xtal_req && !PORT_REGS_AT_RESET) |=> (!XTAL_PIN_ASSIGN && st_r.ev_stat[OSWC_EV_XTAL_REF]))
    else $error("pin assignment not refused");
  xtal_accept_a: assert property (@(posedge CLK) disable iff (!RST_B) // R03
    (xtal_req && PORT_REGS_AT_RESET) |=> XTAL_PIN_ASSIGN)
    else $error("pin assignment not taken");
  hs_src_a: assert property (@(posedge CLK) disable iff (!RST_B) // R05
    ctrl_wr |=> (HS_SRC_EXT == $past(HWDATA[OSWC_HS_SRC_BIT])))
    else $error("high-speed source wrong");
  osc_en_a: assert property (@(posedge CLK) disable iff (!RST_B) // R08
    ctrl_wr |=> (INT_OSC_EN == $past(HWDATA[OSWC_INT_EN_BIT]) && EXT_OSC_EN == $past(HWDATA[OSWC_EXT_EN_BIT])))
    else $error("oscillator enable wrong");
  pll_en_a: assert property (@(posedge CLK) disable iff (!RST_B) // R10
    (ctrl_wr ##1 !ctrl_wr) |-> (PLL_EN == $past(HWDATA[OSWC_PLL_EN_BIT])))
    else $error("PLL enable not held");
  start_busy_a: assert property (@(posedge CLK) disable iff (!RST_B) // R13
    start |=> (WARMUP_BUSY && st_r.wu_cnt == 12'h000))
    else $error("warm-up did not start");
  no_start_a: assert property (@(posedge CLK) disable iff (!RST_B) // R13
    (ctrl_wr && !HWDATA[OSWC_WU_START_BIT] && !WARMUP_BUSY) |=> !WARMUP_BUSY)
    else $error("zero write started warm-up");
  wu_done_a: assert property (@(posedge CLK) disable iff (!RST_B) // R16
    (WARMUP_BUSY && !start && st_r.wu_cnt == st_r.wu_time) |=>
      (!WARMUP_BUSY && st_r.ev_stat[OSWC_EV_WU_DONE]))
    else $error("warm-up did not finish at count");
  busy_read_a: assert property (@(posedge CLK) disable iff (!RST_B) // R12
    (st_r.rd_pend && hits(st_r.addr, OSWC_OFF_CTRL)) |=> (HRDATA[OSWC_WU_BUSY_BIT] == $past(WARMUP_BUSY)))
    else $error("status bit does not track busy");
  start_hidden_a: assert property (@(posedge CLK) disable iff (!RST_B) // R13
    (st_r.rd_pend && hits(st_r.addr, OSWC_OFF_CTRL)) |=> !HRDATA[OSWC_WU_START_BIT])
    else $error("start bit reads back");
  pll_now_a: assert property (@(posedge CLK) disable iff (!RST_B) // R10
    ctrl_wr |=> (PLL_EN == $past(HWDATA[OSWC_PLL_EN_BIT])))
    else $error("PLL enable not written");
  ctrl_static_a: assert property (@(posedge CLK) disable iff (!RST_B) // R01
    !ctrl_wr |=> $stable(ctrl_rd[31:2]))
    else $error("control field moved without write");

  // Pin hand-over; the port block relies on this level to blank its registers
  xtal_clear_a: assert property (@(posedge CLK) disable iff (!RST_B) // R03
    (ctrl_wr && !HWDATA[OSWC_XTAL_BIT]) |=> !XTAL_PIN_ASSIGN)
    else $error("pin assignment not released");
  xtal_static_a: assert property (@(posedge CLK) disable iff (!RST_B) // R03
    !ctrl_wr |=> $stable(XTAL_PIN_ASSIGN))
    else $error("pin assignment moved without write");

  // Warm-up counter; an oscillator edge is seen a few bus cycles late
  cnt_step_a: assert property (@(posedge CLK) disable iff (!RST_B) // R16
    (WARMUP_BUSY && !start && st_r.wu_cnt != st_r.wu_time && src_edge) |=>
      (st_r.wu_cnt == $past(st_r.wu_cnt) + 12'h001))
    else $error("warm-up count missed an edge");
  cnt_wait_a: assert property (@(posedge CLK) disable iff (!RST_B) // R16
    (WARMUP_BUSY && !start && st_r.wu_cnt != st_r.wu_time && !src_edge) |=>
      (WARMUP_BUSY && $stable(st_r.wu_cnt)))
    else $error("warm-up count moved without edge");
  idle_stay_a: assert property (@(posedge CLK) disable iff (!RST_B) // R12
    (!WARMUP_BUSY && !start) |=> !WARMUP_BUSY)
    else $error("warm-up busy without start");

  // Bus side: one read wait state, data held until the next read
  rd_wait_a: assert property (@(posedge CLK) disable iff (!RST_B)
    st_r.rd_pend |=> HREADYOUT)
    else $error("read wait longer than one cycle");
  rdata_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
    !st_r.rd_pend |=> $stable(HRDATA))
    else $error("read data moved outside a read");
  addr_map_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (addr_ok && !st_r.rd_pend && HADDR[31:5] != 27'h000_0000) |=> (st_r.addr == 5'h1F))
    else $error("high address not treated as unmapped");
  unmapped_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (st_r.rd_pend && st_r.addr == 5'h1F) |=> (HRDATA == 32'h0000_0000))
    else $error("unmapped read not zero");

  // Event flags: sticky, cleared only through the clear register
  hs_event_a: assert property (@(posedge CLK) disable iff (!RST_B) // R05
    (ctrl_wr && HWDATA[OSWC_HS_SRC_BIT] && !HS_SRC_EXT) |=> st_r.ev_stat[OSWC_EV_HS_EXT])
    else $error("source switch event missing");
  stat_sticky_a: assert property (@(posedge CLK) disable iff (!RST_B)
    !(st_r.dph_wr && hits(st_r.addr, OSWC_OFF_IRQ_CLR)) |=>
      ((st_r.ev_stat & $past(st_r.ev_stat)) == $past(st_r.ev_stat)))
    else $error("event flag lost without clear");
  irq_clear_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (st_r.dph_wr && hits(st_r.addr, OSWC_OFF_IRQ_CLR) && ev_set == '0) |=>
      (st_r.ev_stat == ($past(st_r.ev_stat) & ~$past(HWDATA[OSWC_NUM_EV-1:0]))))
    else $error("event clear wrong");
  stat_ro_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (st_r.dph_wr && hits(st_r.addr, OSWC_OFF_IRQ_STAT) && ev_set == '0) |=> $stable(st_r.ev_stat))
    else $error("status register took a write");
  en_write_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (st_r.dph_wr && hits(st_r.addr, OSWC_OFF_IRQ_EN)) |=>
      (st_r.ev_en == $past(HWDATA[OSWC_NUM_EV-1:0])))
    else $error("interrupt enable not written");

endmodule : oswc_top

// ===== test/oswc_osc_model.sv
// Purpose: Behavioural oscillators behind the enable outputs
// Assumes: A stopped oscillator holds its output low
// Notes:   Half periods sit off the bus clock grid
`timescale 1ns/100ps
module oswc_osc_model #(
  parameter int INT_HALF = 70,
  parameter int EXT_HALF = 110
) (
  input  wire logic int_en,
  input  wire logic ext_en,
  output logic      int_clk,
  output logic      ext_clk
);
  initial begin
    int_clk = 1'b0;
    ext_clk = 1'b0;
  end
  always #INT_HALF int_clk = int_en ? ~int_clk : 1'b0;
  always #EXT_HALF ext_clk = ext_en ? ~ext_clk : 1'b0;
endmodule : oswc_osc_model

// ===== test/oswc_bench.sv
// Purpose: Register-level bench for the oscillator control block
// Assumes: One AHB-Lite master, model oscillators
// Notes:   Any bus timeout ends the run at once
`timescale 1ns/100ps
module oscillator_select_warmup_control_bench
  import oswc_pkg::*;
;
  localparam logic [31:0] a_ctl  = {27'h0, OSWC_OFF_CTRL};
  localparam logic [31:0] a_stat = {27'h0, OSWC_OFF_IRQ_STAT};
  localparam logic [31:0] a_en   = {27'h0, OSWC_OFF_IRQ_EN};
  localparam logic [31:0] a_clr  = {27'h0, OSWC_OFF_IRQ_CLR};
  logic        clk     = 1'b0;
  logic        rst_b   = 1'b0;
  logic        hwrite  = 1'b0;
  logic        port_ok = 1'b1;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hready, hresp, int_clk, ext_clk, int_en, ext_en, pll_en, hs_ext, wu_ext, xtal, busy, irq;
  int          mismatches = 0;
  int          num_checks = 0;
  always #20 clk = ~clk;
  oswc_top DUT (
    .CLK(clk), .RST_B(rst_b), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .INT_OSC_CLK(int_clk), .EXT_OSC_CLK(ext_clk), .PORT_REGS_AT_RESET(port_ok), .INT_OSC_EN(int_en),
    .EXT_OSC_EN(ext_en), .PLL_EN(pll_en), .HS_SRC_EXT(hs_ext), .WARMUP_SRC_EXT(wu_ext),
    .XTAL_PIN_ASSIGN(xtal), .WARMUP_BUSY(busy), .IRQ(irq)
  );
  oswc_osc_model osc (.int_en(int_en), .ext_en(ext_en), .int_clk(int_clk), .ext_clk(ext_clk));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
  endtask : wait_rdy
  // Address phase held until hready, then data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    @(negedge clk);
  endtask : xfer
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  // Time from start to done must match count of source edges
  task automatic warm(input logic [31:0] d, input int per);
    longint t0;
    int     t;
    int     n;
    xfer(1'b1, a_ctl, d);
    t0 = $time;
    chk({31'h0, busy}, 32'h1);
    rchk(a_ctl, (d & 32'hFFFF_FFFE) | 32'h2);
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    t = int'($time - t0);
    chk({31'h0, t >= (d[31:20] - 1) * per - 40 && t <= d[31:20] * per + 240}, 32'h1);
  endtask : warm
  initial begin
    @(negedge clk);
    chk({24'h0, int_en, ext_en, pll_en, hs_ext, wu_ext, xtal, busy, irq}, 32'h80);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rchk(a_ctl, 32'h8001_0000);
    chk({31'h0, hresp}, 32'h0);
    xfer(1'b1, a_ctl, 32'h0041_0DF4);
    rchk(a_ctl, 32'h0041_0104);
    chk({28'h0, int_en, ext_en, pll_en, hs_ext}, 32'hE);
    xfer(1'b1, a_en, 32'h7);
    rchk(a_stat, 32'h0);
    warm(32'h0041_0105, 140);
    rchk(a_stat, 32'h1);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, a_clr, 32'h1);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, a_ctl, 32'h0043_0104);
    rchk(a_ctl, 32'h0043_0104);
    warm(32'h008A_0105, 220);
    chk({28'h0, int_en, hs_ext, wu_ext, xtal}, 32'h6);
    rchk(a_stat, 32'h5);
    xfer(1'b1, a_clr, 32'h7);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk);
    port_ok <= 1'b0;
    xfer(1'b1, a_ctl, 32'h008E_0104);
    chk({31'h0, xtal}, 32'h0);
    rchk(a_stat, 32'h2);
    @(posedge clk);
    port_ok <= 1'b1;
    xfer(1'b1, a_ctl, 32'h008E_0104);
    chk({31'h0, xtal}, 32'h1);
    rchk(32'h0000_0020, 32'h0);
    xfer(1'b1, a_stat, 32'h7);
    rchk(a_stat, 32'h2);
    end_of_test();
  end
endmodule : oscillator_select_warmup_control_bench
